// ===== include/pmb_defines.svh
// register offsets, field positions, codes and reset values of the blit engine
`ifndef PMB_DEFINES_SVH
`define PMB_DEFINES_SVH
`define PMB_OFF_CMD        16'h9ae8
`define PMB_OFF_FORE_MIX   16'hbae8
`define PMB_OFF_BACK_MIX   16'hb6e8
`define PMB_OFF_FORE_COLOR 16'ha6e8
`define PMB_OFF_BACK_COLOR 16'ha2e8
`define PMB_OFF_WRITE_MASK 16'haae8
`define PMB_OFF_READ_MASK  16'haee8
`define PMB_OFF_PEL_MIX    16'hbee8
`define PMB_OFF_CUR_XY     16'h8100
`define PMB_OFF_DEST_XY    16'h8104
`define PMB_OFF_SIZE       16'h8108
`define PMB_CMD_BLIT       3'h6
`define PMB_CMD_PATTERN    3'h7
`define PMB_CMD_OP_MSB     15
`define PMB_CMD_OP_LSB     13
`define PMB_CMD_MULTI_BIT  1
`define PMB_CMD_XMAJOR_BIT 6
`define PMB_CMD_BUSY_BIT   9
`define PMB_SEL_MSB        7
`define PMB_SEL_LSB        6
`define PMB_SEL_MEMORY     2'h3
`define PMB_MIX_SRC_MSB    6
`define PMB_MIX_SRC_LSB    5
`define PMB_SRC_BACK       2'h0
`define PMB_SRC_FORE       2'h1
`define PMB_SRC_MEMORY     2'h3
`define PMB_MIX_ONE        4'h2
`define PMB_MIX_ZERO       4'h1
`define PMB_MIX_NEW        4'h7
`define PMB_PAT_SIZE       3'h7
`define PMB_RST_MASK       32'hffffffff
`define PMB_RST_MIX        16'h0007
`endif

// ===== include/pmb_pkg.sv
// types of the blit engine
package pmb_pkg;
    typedef enum logic [2:0] {
        PMB_IDLE,
        PMB_READ_SRC,
        PMB_READ_DST,
        PMB_WRITE,
        PMB_STEP
    } pmb_state_type;
endpackage

// ===== design/pmb_blit_engine.sv
// plane masked rectangle copy and pattern tile fill engine with ahb-lite registers
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "pmb_defines.svh"
module pmb_blit_engine #(
    parameter int PIX_W = 8,
    parameter int AW    = 20
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // display memory port, one pixel a cycle, read data one cycle later
    output logic                  mem_req,
    output logic                  mem_we,
    output logic      [AW-1:0]    mem_addr,
    output logic      [PIX_W-1:0] mem_wdata,
    input  wire logic [PIX_W-1:0] mem_rdata,
    // status
    output logic                  busy
);
    localparam int PITCH_LOG = 10;
    logic [15:0]      cmd;
    logic [15:0]      fore_mix_sel;
    logic [15:0]      back_mix_sel;
    logic [31:0]      fore_color_index;
    logic [31:0]      back_color_index;
    logic [31:0]      write_plane_enable;
    logic [31:0]      read_plane_select;
    logic [15:0]      pel_mix_select;
    logic [31:0]      start_position_pair;
    logic [31:0]      dest_pair;
    logic [31:0]      size_pair;
    logic             go;
    pmb_pkg::pmb_state_type state;
    logic [11:0]      cx;
    logic [11:0]      cy;
    logic [PIX_W-1:0] src_pix;
    logic [PIX_W-1:0] dst_pix;
    logic [PIX_W-1:0] next_pix;
    // ahb address phase capture
    logic        ph_wr;
    logic        ph_rd;
    logic [15:0] ph_addr;
    wire         take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr   <= 1'b0;
            ph_rd   <= 1'b0;
            ph_addr <= 16'h0000;
        end else begin
            ph_wr   <= take && hwrite;
            ph_rd   <= take && !hwrite;
            ph_addr <= haddr[15:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign busy      = (state != pmb_pkg::PMB_IDLE);
    // register writes; a command write while busy is dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd                 <= 16'h0000;
            fore_mix_sel        <= `PMB_RST_MIX;
            back_mix_sel        <= `PMB_RST_MIX;
            fore_color_index    <= 32'h00000000;
            back_color_index    <= 32'h00000000;
            write_plane_enable  <= `PMB_RST_MASK;
            read_plane_select   <= `PMB_RST_MASK;
            pel_mix_select      <= 16'h0000;
            start_position_pair <= 32'h00000000;
            dest_pair           <= 32'h00000000;
            size_pair           <= 32'h00000000;
            go                  <= 1'b0;
        end else begin
            go <= 1'b0;
            if (ph_wr) begin
                if (ph_addr == `PMB_OFF_CMD) begin
                    if (!busy) begin
                        cmd <= hwdata[15:0];
                        go  <= 1'b1;
                    end
                end else if (ph_addr == `PMB_OFF_FORE_MIX) begin
                    fore_mix_sel <= hwdata[15:0];
                end else if (ph_addr == `PMB_OFF_BACK_MIX) begin
                    back_mix_sel <= hwdata[15:0];
                end else if (ph_addr == `PMB_OFF_FORE_COLOR) begin
                    fore_color_index <= hwdata;
                end else if (ph_addr == `PMB_OFF_BACK_COLOR) begin
                    back_color_index <= hwdata;
                end else if (ph_addr == `PMB_OFF_WRITE_MASK) begin
                    write_plane_enable <= hwdata;
                end else if (ph_addr == `PMB_OFF_READ_MASK) begin
                    read_plane_select <= hwdata;
                end else if (ph_addr == `PMB_OFF_PEL_MIX) begin
                    pel_mix_select <= hwdata[15:0];
                end else if (ph_addr == `PMB_OFF_CUR_XY) begin
                    start_position_pair <= hwdata;
                end else if (ph_addr == `PMB_OFF_DEST_XY) begin
                    dest_pair <= hwdata;
                end else if (ph_addr == `PMB_OFF_SIZE) begin
                    size_pair <= hwdata;
                end
            end
        end
    end
    // read data; unmapped addresses read zero
    always_comb begin
        hrdata = 32'h00000000;
        if (ph_rd) begin
            if (ph_addr == `PMB_OFF_CMD) begin
                hrdata = {16'h0000, cmd};
                hrdata[`PMB_CMD_BUSY_BIT] = busy;
            end else if (ph_addr == `PMB_OFF_FORE_MIX) begin
                hrdata = {16'h0000, fore_mix_sel};
            end else if (ph_addr == `PMB_OFF_BACK_MIX) begin
                hrdata = {16'h0000, back_mix_sel};
            end else if (ph_addr == `PMB_OFF_FORE_COLOR) begin
                hrdata = fore_color_index;
            end else if (ph_addr == `PMB_OFF_BACK_COLOR) begin
                hrdata = back_color_index;
            end else if (ph_addr == `PMB_OFF_WRITE_MASK) begin
                hrdata = write_plane_enable;
            end else if (ph_addr == `PMB_OFF_READ_MASK) begin
                hrdata = read_plane_select;
            end else if (ph_addr == `PMB_OFF_PEL_MIX) begin
                hrdata = {16'h0000, pel_mix_select};
            end else if (ph_addr == `PMB_OFF_CUR_XY) begin
                hrdata = start_position_pair;
            end else if (ph_addr == `PMB_OFF_DEST_XY) begin
                hrdata = dest_pair;
            end else if (ph_addr == `PMB_OFF_SIZE) begin
                hrdata = size_pair;
            end
        end
    end
    // geometry: x in high half, y in low half
    wire [11:0] src_x  = start_position_pair[27:16];
    wire [11:0] src_y  = start_position_pair[11:0];
    wire [11:0] dst_x  = dest_pair[27:16];
    wire [11:0] dst_y  = dest_pair[11:0];
    wire [11:0] last_x = size_pair[27:16];
    wire [11:0] last_y = size_pair[11:0];
    wire        is_pat = (cmd[`PMB_CMD_OP_MSB:`PMB_CMD_OP_LSB] == `PMB_CMD_PATTERN);
    wire [11:0] abs_x  = dst_x + cx;
    wire [11:0] abs_y  = dst_y + cy;
    // pattern column follows the absolute x modulo 8, so tiles sit on 8 pixel boundaries
    wire [11:0] rd_x = is_pat ? (src_x + {9'h000, abs_x[2:0]}) : (src_x + cx);
    wire [11:0] rd_y = is_pat ? (src_y + {9'h000, abs_y[2:0]}) : (src_y + cy);
    function automatic logic [AW-1:0] pix_addr(input logic [11:0] x, input logic [11:0] y);
        logic [AW+11:0] full;
        full = ({{AW{1'b0}}, y} << PITCH_LOG) + {{AW{1'b0}}, x};
        return full[AW-1:0];
    endfunction
    // only read-enabled planes feed the source bit
    // all enabled planes must be 1 to read a 1
    wire [PIX_W-1:0] rmask   = read_plane_select[PIX_W-1:0];
    wire             src_bit = &(src_pix | ~rmask);
    // memory bit chooses mix register when field 7-6 is 11
    // 1 picks foreground mix, 0 background
    wire        by_mem   = (pel_mix_select[`PMB_SEL_MSB:`PMB_SEL_LSB] == `PMB_SEL_MEMORY);
    wire        use_fore = by_mem ? src_bit : 1'b1;
    wire [15:0] mix      = use_fore ? fore_mix_sel : back_mix_sel;
    // color source of the chosen mix
    // 0027h fore color, 0007h back color, replace
    logic [PIX_W-1:0] color;
    always_comb begin
        case (mix[`PMB_MIX_SRC_MSB:`PMB_MIX_SRC_LSB])
            `PMB_SRC_BACK:   color = back_color_index[PIX_W-1:0];
            `PMB_SRC_FORE:   color = fore_color_index[PIX_W-1:0];
            `PMB_SRC_MEMORY: color = src_pix;
            default:         color = fore_color_index[PIX_W-1:0];
        endcase
    end
    // old destination arrives in the write cycle itself; the register only holds it a cycle later
    wire [PIX_W-1:0] dst_now = (state == pmb_pkg::PMB_WRITE) ? mem_rdata : dst_pix;
    // one and zero mixes ignore source and destination
    // only the 3h mix leaves the destination as it was
    logic [PIX_W-1:0] mixed;
    always_comb begin
        case (mix[3:0])
            `PMB_MIX_ZERO: mixed = {PIX_W{1'b0}};
            `PMB_MIX_ONE:  mixed = {PIX_W{1'b1}};
            4'h0:          mixed = ~dst_now;
            4'h3:          mixed = dst_now;
            4'h4:          mixed = ~color;
            4'h5:          mixed = color ^ dst_now;
            4'h6:          mixed = ~(color ^ dst_now);
            4'hb:          mixed = color | dst_now;
            4'hf:          mixed = color & dst_now;
            default:       mixed = color;
        endcase
    end
    wire [PIX_W-1:0] wmask = write_plane_enable[PIX_W-1:0];
    assign next_pix = (mixed & wmask) | (dst_now & ~wmask);

    // copy and across-plane copy share one command; path differs only by mix and masks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state   <= pmb_pkg::PMB_IDLE;
            cx      <= 12'h000;
            cy      <= 12'h000;
            src_pix <= {PIX_W{1'b0}};
            dst_pix <= {PIX_W{1'b0}};
        end else begin
            case (state)
                pmb_pkg::PMB_IDLE: begin
                    cx <= 12'h000;
                    cy <= 12'h000;
                    if (go && (cmd[`PMB_CMD_OP_MSB:`PMB_CMD_OP_LSB] == `PMB_CMD_BLIT || is_pat)) begin
                        state <= pmb_pkg::PMB_READ_SRC;
                    end
                end
                pmb_pkg::PMB_READ_SRC: begin
                    state <= pmb_pkg::PMB_READ_DST;
                end
                pmb_pkg::PMB_READ_DST: begin
                    src_pix <= mem_rdata;
                    state   <= pmb_pkg::PMB_WRITE;
                end
                pmb_pkg::PMB_WRITE: begin
                    dst_pix <= mem_rdata;
                    state   <= pmb_pkg::PMB_STEP;
                end
                pmb_pkg::PMB_STEP: begin
                    // walking stops at the rectangle edge, nothing outside is written
                    if (cx != last_x) begin
                        cx    <= cx + 12'h001;
                        state <= pmb_pkg::PMB_READ_SRC;
                    end else if (cy != last_y) begin
                        cx    <= 12'h000;
                        cy    <= cy + 12'h001;
                        state <= pmb_pkg::PMB_READ_SRC;
                    end else begin
                        state <= pmb_pkg::PMB_IDLE;
                    end
                end
                default: state <= pmb_pkg::PMB_IDLE;
            endcase
        end
    end
    // memory port; write data registered so it stands with the write cycle
    always_comb begin
        mem_req  = 1'b0;
        mem_we   = 1'b0;
        mem_addr = {AW{1'b0}};
        if (state == pmb_pkg::PMB_READ_SRC) begin
            mem_req  = 1'b1;
            mem_addr = pix_addr(rd_x, rd_y);
        end else if (state == pmb_pkg::PMB_READ_DST) begin
            mem_req  = 1'b1;
            mem_addr = pix_addr(abs_x, abs_y);
        end else if (state == pmb_pkg::PMB_STEP) begin
            mem_req  = 1'b1;
            mem_we   = 1'b1;
            mem_addr = pix_addr(abs_x, abs_y);
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_wdata <= {PIX_W{1'b0}};
        end else if (state == pmb_pkg::PMB_WRITE) begin
            mem_wdata <= next_pix;
        end
    end
    // checks
    chk_mix_one_const: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == pmb_pkg::PMB_WRITE && mix[3:0] == `PMB_MIX_ONE)
        |=> (mem_wdata == (dst_pix | wmask)))
        else $error("one mix did not give ones");
    chk_mix_zero_const: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == pmb_pkg::PMB_WRITE && mix[3:0] == `PMB_MIX_ZERO)
        |=> (mem_wdata == (dst_pix & ~wmask)))
        else $error("zero mix did not give zeros");
    chk_plane_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == pmb_pkg::PMB_STEP) |-> ((mem_wdata & ~wmask) == (dst_pix & ~wmask)))
        else $error("disabled plane changed");
    chk_read_and: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == pmb_pkg::PMB_WRITE && (src_pix & rmask) != rmask) |-> !src_bit)
        else $error("and of read planes wrong");
    chk_mix_by_mem: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == pmb_pkg::PMB_WRITE && by_mem) |-> (mix == (src_bit ? fore_mix_sel : back_mix_sel)))
        else $error("mix choice wrong");
    chk_fore_color: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == pmb_pkg::PMB_WRITE && mix[6:0] == 7'h27 && wmask == {PIX_W{1'b1}})
        |=> (mem_wdata == $past(fore_color_index[PIX_W-1:0])))
        else $error("foreground color not written");
    chk_tile_align: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == pmb_pkg::PMB_READ_SRC && is_pat) |-> (rd_x - src_x) == {9'h000, abs_x[2:0]})
        else $error("pattern column misaligned");
    sequence s_pixel;
        state == pmb_pkg::PMB_READ_SRC ##1 state == pmb_pkg::PMB_READ_DST
        ##1 state == pmb_pkg::PMB_WRITE ##1 (state == pmb_pkg::PMB_STEP && mem_we);
    endsequence
    chk_copy_start: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == pmb_pkg::PMB_IDLE && go && cmd[15:13] == `PMB_CMD_BLIT) |=> s_pixel)
        else $error("copy command did not run");
    chk_inside_rect: assert property (@(posedge hclk) disable iff (!hresetn)
        mem_we |-> (cx <= last_x && cy <= last_y))
        else $error("write outside rectangle");
endmodule
`default_nettype wire

// ===== test/plane_masked_blit_and_pattern_fill_test.sv
// self-checking bench for the plane masked blit and pattern fill engine
`timescale 1ns/100ps
`default_nettype none
`include "pmb_defines.svh"
module plane_masked_blit_and_pattern_fill_test;
    logic        hclk = 1'b0;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        mem_req;
    logic        mem_we;
    logic [19:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata = 8'h00;
    logic        busy;
    logic [7:0]  vram    [0:1048575];
    logic [7:0]  ref_mem [0:1048575];
    logic [31:0] c_rm, c_wm, c_fc, c_bc;
    logic [15:0] c_fm, c_bm, c_sel;
    logic [31:0] q;
    int          miscompares, n_checks, cycles;
    logic [15:0] r_addr [6] = '{`PMB_OFF_READ_MASK, `PMB_OFF_WRITE_MASK, `PMB_OFF_FORE_MIX,
                                `PMB_OFF_BACK_MIX, `PMB_OFF_PEL_MIX, `PMB_OFF_FORE_COLOR};
    logic [31:0] r_exp [6] = '{32'hffffffff, 32'hffffffff, 32'h00000007, 32'h00000007, 32'h0, 32'h0};

    assign hready = hreadyout;
    always #10 hclk = ~hclk;

    pmb_blit_engine #(.PIX_W(8), .AW(20)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .busy(busy));

    // display memory: read data one cycle after the request, garbage otherwise
    always @(posedge hclk) begin
        if (mem_req === 1'b1 && mem_we === 1'b1) vram[mem_addr] <= mem_wdata;
        if (mem_req === 1'b1 && mem_we === 1'b0) mem_rdata <= vram[mem_addr];
        else mem_rdata <= ~mem_rdata;
    end

    // a hang ends the run as a failure
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one single ahb-lite transfer; hready always sampled, never assumed
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {16'h0, a};
        hsize  <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic setup(input logic [31:0] rm, wm, input logic [15:0] fm, bm,
                         input logic [31:0] fc, bc, input logic [15:0] sel);
        c_rm = rm; c_wm = wm; c_fm = fm; c_bm = bm; c_fc = fc; c_bc = bc; c_sel = sel;
        wr(`PMB_OFF_READ_MASK, rm);
        wr(`PMB_OFF_WRITE_MASK, wm);
        wr(`PMB_OFF_FORE_MIX, {16'h0, fm});
        wr(`PMB_OFF_BACK_MIX, {16'h0, bm});
        wr(`PMB_OFF_FORE_COLOR, fc);
        wr(`PMB_OFF_BACK_COLOR, bc);
        wr(`PMB_OFF_PEL_MIX, {16'h0, sel});
    endtask

    // expected pixel from source value and old destination
    function automatic logic [7:0] mixf(input logic [7:0] s, input logic [7:0] d);
        logic       b;
        logic [15:0] m;
        logic [7:0] v, r;
        b = (c_sel[7:6] == `PMB_SEL_MEMORY) ? &(s | ~c_rm[7:0]) : 1'b1;
        m = b ? c_fm : c_bm;
        case (m[6:5])
            `PMB_SRC_BACK: v = c_bc[7:0];
            `PMB_SRC_FORE: v = c_fc[7:0];
            default:       v = s;
        endcase
        case (m[3:0])
            `PMB_MIX_ONE:  r = 8'hff;
            `PMB_MIX_ZERO: r = 8'h00;
            4'h5:          r = v ^ d;
            default:       r = v;
        endcase
        return (r & c_wm[7:0]) | (d & ~c_wm[7:0]);
    endfunction

    // launch one operation, disturb a blit or pattern run with a second command, then compare a bordered box
    task automatic run(input logic [15:0] cmd, input int sx, sy, dx, dy, w, h);
        logic       ok, pat;
        logic [7:0] s;
        int         i, x, y, a;
        ok  = (cmd[15:13] == `PMB_CMD_BLIT) || (cmd[15:13] == `PMB_CMD_PATTERN);
        pat = (cmd[15:13] == `PMB_CMD_PATTERN);
        wr(`PMB_OFF_CUR_XY, {4'h0, 12'(sx), 4'h0, 12'(sy)});
        wr(`PMB_OFF_DEST_XY, {4'h0, 12'(dx), 4'h0, 12'(dy)});
        wr(`PMB_OFF_SIZE, {4'h0, 12'(w - 1), 4'h0, 12'(h - 1)});
        wr(`PMB_OFF_CMD, {16'h0, cmd});
        if (ok) begin
            bus(1'b0, `PMB_OFF_CMD, 32'h0, q);
            check("busy bit", 32'h1, {31'h0, q[`PMB_CMD_BUSY_BIT]});
            // a second command while running must not take effect
            wr(`PMB_OFF_CMD, {16'h0, cmd ^ 16'h2000});
            i = 0;
            while (busy !== 1'b0 && i < 2000) begin
                @(posedge hclk);
                i++;
            end
            check("busy end", 32'h0, {31'h0, busy});
        end else begin
            repeat (4) @(posedge hclk);
            check("busy idle", 32'h0, {31'h0, busy});
        end
        @(posedge hclk);
        for (y = 0; y < h && ok; y++) begin
            for (x = 0; x < w; x++) begin
                a = (dy + y) * 1024 + dx + x;
                if (pat) s = ref_mem[(sy + (dy + y) % 8) * 1024 + sx + (dx + x) % 8];
                else s = ref_mem[(sy + y) * 1024 + sx + x];
                ref_mem[a] = mixf(s, ref_mem[a]);
            end
        end
        for (y = -1; y <= h; y++) begin
            for (x = -1; x <= w; x++) begin
                a = (dy + y) * 1024 + dx + x;
                check("pixel", {24'h0, ref_mem[a]}, {24'h0, vram[a]});
            end
        end
    endtask

    initial begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        for (int k = 0; k < 1048576; k++) begin
            vram[k]    = 8'(k * 37 + (k >> 10) * 11);
            ref_mem[k] = 8'(k * 37 + (k >> 10) * 11);
        end
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            bus(1'b0, r_addr[k], 32'h0, q);
            check("reset value", r_exp[k], q);
        end
        // unmapped place: writes lost, reads zero
        wr(16'h1234, 32'hdeadbeef);
        bus(1'b0, 16'h1234, 32'h0, q);
        check("unmapped", 32'h0, q);
        // through copy with planes 7-4 protected
        setup(32'hff, 32'h0f, 16'h0067, 16'h0007, 32'h0, 32'h0, 16'ha000);
        run(16'hc040, 0, 0, 100, 20, 5, 3);
        // xor with the old destination, upper planes only
        setup(32'hff, 32'hf0, 16'h0065, 16'h0007, 32'h0, 32'h0, 16'ha000);
        run(16'hc040, 0, 0, 600, 20, 4, 2);
        // across-plane copy, plane 0 into plane 2
        setup(32'h1, 32'h4, 16'h0002, 16'h0001, 32'h0, 32'h0, 16'ha0c0);
        bus(1'b0, `PMB_OFF_PEL_MIX, 32'h0, q);
        check("select readback", 32'h0000a0c0, q);
        run(16'hc042, 0, 0, 200, 20, 6, 4);
        // two read planes must both be set
        setup(32'h3, 32'h4, 16'h0002, 16'h0001, 32'h0, 32'h0, 16'ha0c0);
        run(16'hc042, 0, 0, 300, 20, 6, 4);
        // monochrome expansion to two colours
        setup(32'h1, 32'hffffffff, 16'h0027, 16'h0007, 32'h4, 32'h1, 16'ha0c0);
        run(16'hc042, 0, 0, 400, 20, 6, 4);
        // pattern tiles at an unaligned destination, border untouched
        setup(32'hff, 32'hffffffff, 16'h0067, 16'h0007, 32'h0, 32'h0, 16'ha000);
        run(16'he040, 0, 40, 13, 60, 11, 10);
        // an unknown command code draws nothing
        run(16'h2040, 0, 0, 500, 20, 4, 2);
        close_out();
    end
endmodule
`default_nettype wire
